// ### hdl/apc_pkg.sv
package apc_pkg;
    // ==========================================================
    // sample rate
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned SAMPLE_DIV = 5;
    localparam logic [2:0] DIV_LAST = 3'(SAMPLE_DIV - 1);

    // ==========================================================
    // widths
    localparam int unsigned SAMPLE_W = 16;
    localparam int unsigned PROD_W = 32;
    localparam int unsigned WAVE_DROP = 10;
    localparam int unsigned WAVE_W = PROD_W - WAVE_DROP;
    localparam int unsigned LPF_SHIFT = 6;
    localparam int unsigned GAIN_W = 12;
    localparam int unsigned GAIN_SHIFT = 12;
    localparam int unsigned OFFSET_W = 16;
    localparam int unsigned OFFSET_FRAC = 8;
    localparam int unsigned POWER_W = 32;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;

    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [7:0] REG_NO_LOAD_SELECT = 8'h0e;
    localparam logic [7:0] REG_ACCUM_CONTROL = 8'h0f;
    localparam logic [7:0] REG_POWER_GAIN = 8'h1d;
    localparam logic [7:0] REG_POWER_OFFSET = 8'h20;
    localparam logic [7:0] REG_ACTIVE_POWER = 8'h21;
    localparam logic [7:0] REG_IRQ_ENABLE_LOW = 8'hd9;
    localparam logic [7:0] REG_IRQ_STATUS_LOW = 8'hdc;
    localparam logic [7:0] REG_IRQ_CLEAR_LOW = 8'hdd;

    // ==========================================================
    // field positions
    localparam int unsigned BIT_NO_LOAD = 0;
    localparam int unsigned BIT_POWER_SIGN = 3;
    localparam int unsigned BIT_SIGN_DIR = 4;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_NO_LOAD_SELECT = 8'h00;
    localparam logic [7:0] RST_ACCUM_CONTROL = 8'h00;
    localparam logic [11:0] RST_POWER_GAIN = 12'h000;
    localparam logic [15:0] RST_POWER_OFFSET = 16'h0000;
    localparam logic [7:0] RST_IRQ_ENABLE_LOW = 8'h00;

    // ==========================================================
    // no-load thresholds in waveform lsbs: 0.015, 0.0075, 0.0037 percent
    localparam logic [21:0] NL_THR_1 = 22'h00013b;
    localparam logic [21:0] NL_THR_2 = 22'h00009d;
    localparam logic [21:0] NL_THR_3 = 22'h00004e;
endpackage : apc_pkg

// ### hdl/apc_lowpass.sv
module apc_lowpass #(
    parameter int unsigned W = 22,
    parameter int unsigned SHIFT = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // sample stream
    input wire logic en,
    input wire logic signed [W-1:0] x,
    output logic signed [W-1:0] y
);
    logic signed [W+SHIFT-1:0] acc;
    logic signed [W+SHIFT-1:0] next_acc;

    // ==========================================================
    // first order iir: y += (x - y) / 2^shift
    always_comb begin
        next_acc = acc + (W+SHIFT)'(x) - (acc >>> SHIFT);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            acc <= '0;
        end else if (en) begin
            acc <= next_acc;
        end
    end

    assign y = acc[W+SHIFT-1:SHIFT];
endmodule // apc_lowpass

// ### hdl/apc_gain_offset.sv
module apc_gain_offset (
    // filtered power
    input wire logic signed [apc_pkg::WAVE_W-1:0] filt,
    // calibration
    input wire logic [apc_pkg::GAIN_W-1:0] gain,
    input wire logic [apc_pkg::OFFSET_W-1:0] offset,
    // calibrated power, 8 fraction bits
    output logic signed [apc_pkg::POWER_W-1:0] power
);
    import apc_pkg::*;
    logic signed [GAIN_W+1:0] factor;
    logic signed [WAVE_W+GAIN_W+1:0] prod;
    logic signed [WAVE_W+1:0] gained;

    // ==========================================================
    // scale by 1 + gain/4096, then add offset in 1/256 lsb
    always_comb begin
        factor = (GAIN_W+2)'(1 << GAIN_SHIFT) + (GAIN_W+2)'($signed(gain));
        prod = (WAVE_W+GAIN_W+2)'(filt) * (WAVE_W+GAIN_W+2)'(factor);
        gained = prod[WAVE_W+GAIN_SHIFT+1:GAIN_SHIFT];
        power = (POWER_W)'(gained) * (POWER_W)'(1 << OFFSET_FRAC)
            + (POWER_W)'($signed(offset));
    end
endmodule // apc_gain_offset

// ### hdl/apc_active_power.sv
// How it works
// - multiply current by voltage, low-pass filter product
// - scale power by one plus gain over 4096
// - add offset, 256 offset lsbs per sample lsb
// - direction clear: flag positive to negative transition
// - direction set: flag negative to positive transition
// - enabled sign flag holds interrupt while set
// - gate accumulation while product below no-load threshold
// - flag no-load while power below threshold
// - enabled no-load flag holds interrupt until cleared
// - no-load field: off, 0.015, 0.0075, 0.0037 percent
// - one power sample every five clocks
//
// The Avalon-MM slave port was left to the implementer.
module apc_active_power (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // sample streams
    input wire logic signed [apc_pkg::SAMPLE_W-1:0] current_sample,
    input wire logic signed [apc_pkg::SAMPLE_W-1:0] voltage_sample,
    // avalon-mm slave
    input wire logic [apc_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [apc_pkg::DATA_W-1:0] writedata,
    output logic [apc_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    // power outputs
    output logic signed [apc_pkg::POWER_W-1:0] active_power,
    output logic power_valid,
    output logic accumulate_enable,
    // interrupt
    output logic irq
);
    import apc_pkg::*;

    typedef struct packed {
        logic [2:0] div_count;
        logic tick_d1;
        logic waitrequest;
        logic [DATA_W-1:0] readdata;
        logic [7:0] no_load_select;
        logic [7:0] accumulation_control;
        logic [GAIN_W-1:0] power_gain;
        logic [OFFSET_W-1:0] power_offset;
        logic [7:0] irq_enable_low;
        logic [7:0] irq_status_low;
        logic irq;
        logic [POWER_W-1:0] active_power;
        logic power_valid;
        logic accumulate_enable;
        logic prev_negative;
    } apc_state_s;

    apc_state_s s;
    apc_state_s next_s;

    logic tick;
    logic [7:0] idx;
    logic req;
    logic nl_on;
    logic [WAVE_W-1:0] thr;
    logic signed [PROD_W-1:0] product;
    logic signed [WAVE_W-1:0] wave;
    logic signed [WAVE_W-1:0] filt;
    logic signed [POWER_W-1:0] power_next;
    logic [WAVE_W-1:0] wave_mag;
    logic [POWER_W-1:0] pow_mag;
    logic [POWER_W-1:0] pow_thr;
    logic neg;
    logic sign_event;

    // ==========================================================
    // power path
    always_comb begin
        product = PROD_W'(current_sample) * PROD_W'(voltage_sample);
        wave = product[PROD_W-1:WAVE_DROP];
    end

    apc_lowpass #(
        .W(WAVE_W),
        .SHIFT(LPF_SHIFT)
    ) u_power_lowpass (
        .clk(clk),
        .reset(reset),
        .en(tick),
        .x(wave),
        .y(filt)
    );

    apc_gain_offset u_gain_offset (
        .filt(filt),
        .gain(s.power_gain),
        .offset(s.power_offset),
        .power(power_next)
    );

    // ==========================================================
    // no-load and sign detection
    always_comb begin
        nl_on = (s.no_load_select[1:0] != 2'h0);
        case (s.no_load_select[1:0])
            2'h1: thr = NL_THR_1;
            2'h2: thr = NL_THR_2;
            2'h3: thr = NL_THR_3;
            default: thr = '0;
        endcase
        wave_mag = wave[WAVE_W-1] ? WAVE_W'(-wave) : WAVE_W'(wave);
        pow_mag = power_next[POWER_W-1] ? POWER_W'(-power_next) : POWER_W'(power_next);
        pow_thr = POWER_W'(thr) << OFFSET_FRAC;
        neg = power_next[POWER_W-1];
        if (s.accumulation_control[BIT_SIGN_DIR]) begin
            sign_event = s.prev_negative && !neg;
        end else begin
            sign_event = !s.prev_negative && neg;
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        next_s = s;
        idx = address[ADDR_W-1:2];
        req = read || write;
        tick = (s.div_count == DIV_LAST);
        next_s.power_valid = 1'b0;
        next_s.tick_d1 = tick;
        next_s.div_count = tick ? 3'h0 : s.div_count + 3'h1;
        if (tick) begin
            next_s.accumulate_enable = !(nl_on && (wave_mag < thr));
        end
        // bus: one wait state, read data loaded while waiting
        next_s.waitrequest = !(req && s.waitrequest);
        if (read && s.waitrequest) begin
            case (idx)
                REG_NO_LOAD_SELECT: next_s.readdata = {24'h000000, s.no_load_select};
                REG_ACCUM_CONTROL: next_s.readdata = {24'h000000, s.accumulation_control};
                REG_POWER_GAIN: next_s.readdata = {20'h00000, s.power_gain};
                REG_POWER_OFFSET: next_s.readdata = {16'h0000, s.power_offset};
                REG_ACTIVE_POWER: next_s.readdata = s.active_power;
                REG_IRQ_ENABLE_LOW: next_s.readdata = {24'h000000, s.irq_enable_low};
                REG_IRQ_STATUS_LOW: next_s.readdata = {24'h000000, s.irq_status_low};
                default: next_s.readdata = 32'h00000000;
            endcase
        end
        if (write && !s.waitrequest) begin
            case (idx)
                REG_NO_LOAD_SELECT: next_s.no_load_select = writedata[7:0];
                REG_ACCUM_CONTROL: next_s.accumulation_control = writedata[7:0];
                REG_POWER_GAIN: next_s.power_gain = writedata[GAIN_W-1:0];
                REG_POWER_OFFSET: next_s.power_offset = writedata[OFFSET_W-1:0];
                REG_IRQ_ENABLE_LOW: next_s.irq_enable_low = writedata[7:0];
                REG_IRQ_CLEAR_LOW: next_s.irq_status_low = s.irq_status_low & ~writedata[7:0];
                default: next_s.readdata = s.readdata;
            endcase
        end
        // sample update; sets come after clears so a set wins
        if (s.tick_d1) begin
            next_s.active_power = power_next;
            next_s.power_valid = 1'b1;
            next_s.prev_negative = neg;
            if (sign_event) begin
                next_s.irq_status_low[BIT_POWER_SIGN] = 1'b1;
            end
            if (nl_on && (pow_mag < pow_thr)) begin
                next_s.irq_status_low[BIT_NO_LOAD] = 1'b1;
            end
        end
        next_s.irq = |(next_s.irq_status_low & next_s.irq_enable_low);
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
            s.waitrequest <= 1'b1;
            s.accumulate_enable <= 1'b1;
            s.no_load_select <= RST_NO_LOAD_SELECT;
            s.accumulation_control <= RST_ACCUM_CONTROL;
            s.power_gain <= RST_POWER_GAIN;
            s.power_offset <= RST_POWER_OFFSET;
            s.irq_enable_low <= RST_IRQ_ENABLE_LOW;
        end else begin
            s <= next_s;
        end
    end

    assign readdata = s.readdata;
    assign waitrequest = s.waitrequest;
    assign active_power = s.active_power;
    assign power_valid = s.power_valid;
    assign accumulate_enable = s.accumulate_enable;
    assign irq = s.irq;

    // ==========================================================
    // assertions
    property p_sample_period;
        @(posedge clk) disable iff (reset)
        tick |=> !tick [*4] ##1 tick;
    endproperty
    a_sample_period: assert property (p_sample_period)
        else $error("sample tick not every five clocks");

    property p_power_latency;
        @(posedge clk) disable iff (reset)
        tick |-> ##2 (s.power_valid && s.active_power == $past(power_next));
    endproperty
    a_power_latency: assert property (p_power_latency)
        else $error("filtered power not presented two clocks after tick");

    property p_unity_gain;
        @(posedge clk) disable iff (reset)
        (s.tick_d1 && s.power_gain == 12'h000 && s.power_offset == 16'h0000)
            |=> s.active_power == POWER_W'($past(filt)) * POWER_W'(256);
    endproperty
    a_unity_gain: assert property (p_unity_gain)
        else $error("zero gain does not pass filter output unchanged");

    property p_offset_add;
        @(posedge clk) disable iff (reset)
        (s.tick_d1 && s.power_gain == 12'h000)
            |=> s.active_power == POWER_W'($past(filt)) * POWER_W'(256)
                + POWER_W'($signed($past(s.power_offset)));
    endproperty
    a_offset_add: assert property (p_offset_add)
        else $error("power offset not added at 1/256 lsb");

    property p_sign_pos_neg;
        @(posedge clk) disable iff (reset)
        (s.tick_d1 && !s.accumulation_control[4] && !s.prev_negative && neg)
            |=> s.irq_status_low[3];
    endproperty
    a_sign_pos_neg: assert property (p_sign_pos_neg)
        else $error("positive to negative transition not flagged");

    property p_sign_neg_pos;
        @(posedge clk) disable iff (reset)
        (s.tick_d1 && s.accumulation_control[4] && s.prev_negative && !neg)
            |=> s.irq_status_low[3];
    endproperty
    a_sign_neg_pos: assert property (p_sign_neg_pos)
        else $error("negative to positive transition not flagged");

    property p_sign_irq;
        @(posedge clk) disable iff (reset)
        (s.irq_status_low[3] && s.irq_enable_low[3]) |-> s.irq;
    endproperty
    a_sign_irq: assert property (p_sign_irq)
        else $error("enabled sign flag without interrupt");

    property p_creep_gate;
        @(posedge clk) disable iff (reset)
        (tick && nl_on && wave_mag < thr) |=> !s.accumulate_enable;
    endproperty
    a_creep_gate: assert property (p_creep_gate)
        else $error("accumulation not gated below no-load threshold");

    property p_no_load_flag;
        @(posedge clk) disable iff (reset)
        (s.tick_d1 && nl_on && pow_mag < pow_thr) |=> s.irq_status_low[0];
    endproperty
    a_no_load_flag: assert property (p_no_load_flag)
        else $error("no-load flag not set below threshold");

    property p_no_load_irq;
        @(posedge clk) disable iff (reset)
        (s.irq_status_low[0] && s.irq_enable_low[0]) |-> s.irq;
    endproperty
    a_no_load_irq: assert property (p_no_load_irq)
        else $error("enabled no-load flag without interrupt");

    property p_no_load_off;
        @(posedge clk) disable iff (reset)
        (tick && s.no_load_select[1:0] == 2'b00) |=> s.accumulate_enable;
    endproperty
    a_no_load_off: assert property (p_no_load_off)
        else $error("no-load gating active while disabled");

    property p_flag_sticky;
        @(posedge clk) disable iff (reset)
        (s.irq_status_low[3] && !(write && !s.waitrequest
            && idx == REG_IRQ_CLEAR_LOW && writedata[3])) |=> s.irq_status_low[3];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("sign flag dropped without a clear");

    property p_valid_cadence;
        @(posedge clk) disable iff (reset)
        s.power_valid |=> !s.power_valid [*4] ##1 s.power_valid;
    endproperty
    a_valid_cadence: assert property (p_valid_cadence)
        else $error("power valid not every five clocks");

    property p_no_load_sticky;
        @(posedge clk) disable iff (reset)
        (s.irq_status_low[BIT_NO_LOAD] && !(write && !s.waitrequest
            && idx == REG_IRQ_CLEAR_LOW && writedata[BIT_NO_LOAD]))
            |=> s.irq_status_low[BIT_NO_LOAD];
    endproperty
    a_no_load_sticky: assert property (p_no_load_sticky)
        else $error("no-load flag dropped without a clear");

    property p_no_load_clear;
        @(posedge clk) disable iff (reset)
        (write && !s.waitrequest && idx == REG_IRQ_CLEAR_LOW && writedata[BIT_NO_LOAD]
            && !(s.tick_d1 && nl_on && pow_mag < pow_thr)) |=> !s.irq_status_low[BIT_NO_LOAD];
    endproperty
    a_no_load_clear: assert property (p_no_load_clear)
        else $error("no-load flag not cleared by software");
endmodule // apc_active_power

// ### sim/tb_active_power_calc.sv
module tb_active_power_calc;
    timeunit 1ns;
    timeprecision 1ps;
    import apc_pkg::*;
    // ==========================================================
    // signals
    logic clk, reset, read, write, waitrequest, power_valid, accumulate_enable, irq;
    logic signed [15:0] current_sample, voltage_sample;
    logic [9:0] address;
    logic [31:0] writedata, readdata, rd;
    logic signed [31:0] active_power;
    int err_total, check_count, cyc;
    apc_active_power uut (.clk(clk), .reset(reset), .current_sample(current_sample),
        .voltage_sample(voltage_sample), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .active_power(active_power), .power_valid(power_valid),
        .accumulate_enable(accumulate_enable), .irq(irq));
    // ==========================================================
    // bus and compare tasks
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge clk);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= wd;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic check_near(input string nm, input int exp, input logic signed [31:0] got);
        check_count++;
        if ((^got === 1'bx) || (got - exp > 32768) || (exp - got > 32768)) begin
            err_total++;
            $display("wrong value %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        bus(idx, 1'b0, 0);
        check(nm, exp, rd);
    endtask
    task automatic samples(input int c, input int v, input int n);
        current_sample <= 16'(c);
        voltage_sample <= 16'(v);
        repeat (n) @(posedge clk);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [7:0] idx [5] = '{8'h0e, 8'h0f, 8'h1d, 8'h20, 8'hd9};
        foreach (idx[i]) rd_chk("reset value", idx[i], 0);
        check("irq after reset", 0, irq);
        check("accumulate after reset", 1, accumulate_enable);
        bus(8'h1d, 1'b1, 32'hffffffff);
        rd_chk("gain width", 8'h1d, 32'h00000fff);
        bus(8'h1d, 1'b1, 0);
        bus(8'h40, 1'b1, 32'h12345678);
        rd_chk("unmapped", 8'h40, 0);
        $display("test regs done");
    endtask
    task automatic t_offset();
        samples(0, 0, 20);
        bus(8'h20, 1'b1, 32'h0100);
        repeat (20) @(posedge clk);
        rd_chk("offset one lsb", 8'h21, 256);
        bus(8'h20, 1'b1, 32'h8000);
        repeat (20) @(posedge clk);
        rd_chk("offset negative", 8'h21, 32'hffff8000);
        check("power port", 32'hffff8000, active_power);
        bus(8'h20, 1'b1, 0);
        $display("test offset done");
    endtask
    task automatic t_gain();
        int g [3] = '{0, 2047, -2048};
        samples(16384, 16384, 3000);
        foreach (g[i]) begin
            bus(8'h1d, 1'b1, 32'(g[i]) & 32'hfff);
            repeat (20) @(posedge clk);
            bus(8'h21, 1'b0, 0);
            check_near("scaled power", 67108864 + 16384 * g[i], rd);
        end
        bus(8'h1d, 1'b1, 0);
        $display("test gain done");
    endtask
    task automatic t_sign();
        bus(8'hd9, 1'b1, 32'h08);
        bus(8'hdd, 1'b1, 32'hff);
        rd_chk("no change yet", 8'hdc, 0);
        samples(-16384, 16384, 800);
        rd_chk("pos to neg flag", 8'hdc, 32'h08);
        check("sign irq", 1, irq);
        repeat (200) @(posedge clk);
        rd_chk("sign sticky", 8'hdc, 32'h08);
        bus(8'hdd, 1'b1, 32'h08);
        rd_chk("sign cleared", 8'hdc, 0);
        check("sign irq off", 0, irq);
        bus(8'h0f, 1'b1, 32'h10);
        samples(16384, 16384, 800);
        rd_chk("neg to pos flag", 8'hdc, 32'h08);
        check("sign irq dir", 1, irq);
        bus(8'hd9, 1'b1, 0);
        @(posedge clk);
        check("sign irq masked", 0, irq);
        bus(8'hdd, 1'b1, 32'h08);
        samples(-16384, 16384, 800);
        rd_chk("pos to neg ignored", 8'hdc, 0);
        bus(8'h0f, 1'b1, 0);
        $display("test sign done");
    endtask
    task automatic t_noload();
        int thr [4] = '{0, 315, 157, 78};
        int w [2] = '{200, 100};
        bit open;
        for (int m = 0; m < 4; m++) begin
            bus(8'h0e, 1'b1, 32'(m));
            foreach (w[k]) begin
                samples(2 * w[k], 512, 12);
                open = (m == 0) || (w[k] >= thr[m]);
                check("creep gate", 32'(open), 32'(accumulate_enable));
            end
        end
        bus(8'h0e, 1'b1, 0);
        bus(8'hd9, 1'b1, 32'h01);
        samples(0, 0, 3000);
        bus(8'hdd, 1'b1, 32'hff);
        repeat (20) @(posedge clk);
        rd_chk("no-load disabled", 8'hdc, 0);
        bus(8'h0e, 1'b1, 1);
        repeat (20) @(posedge clk);
        bus(8'hdc, 1'b0, 0);
        check("no-load flag", 1, rd & 1);
        check("no-load irq", 1, irq);
        samples(16384, 16384, 800);
        bus(8'hdc, 1'b0, 0);
        check("no-load sticky", 1, rd & 1);
        check("no-load irq held", 1, irq);
        bus(8'hdd, 1'b1, 32'h01);
        bus(8'hdc, 1'b0, 0);
        check("no-load cleared", 0, rd & 1);
        check("no-load irq off", 0, irq);
        $display("test noload done");
    endtask
    task automatic t_rate();
        int n, gap;
        n = 0;
        gap = 0;
        @(posedge clk);
        while (power_valid !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        do begin
            @(posedge clk);
            gap++;
        end while (power_valid !== 1'b1 && gap < 20);
        check("sample spacing", 5, gap);
        $display("test rate done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // clock, timeout and main sequence
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 60000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        reset = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        current_sample = '0;
        voltage_sample = '0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_offset();
        t_gain();
        t_sign();
        t_noload();
        t_rate();
        wrap_up();
    end
endmodule // tb_active_power_calc
